// ==== twe_pkg.sv ====
/*
  Package for the trigger width exposure controller: register map, field
  positions, reset values, offset bands and timing constants.
  Assumes a single 10 MHz clock and a 32-bit AHB-Lite register bus.
*/
package twe_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THROUGHPUT = 8'h04;
  localparam logic [7:0] ADDR_EXP_TIME = 8'h08;
  localparam logic [7:0] ADDR_OVERLAP_MAX = 8'h0C;
  localparam logic [7:0] ADDR_TRIG_DELAY = 8'h10;
  localparam logic [7:0] ADDR_SW_TRIGGER = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MIN_EXP = 8'h1C;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STAT_OVERRUN_BIT = 2;
  localparam logic [19:0] EXP_TIME_RESET = 20'h00BB8;
  localparam logic [19:0] OVERLAP_RESET = 20'h00000;
  localparam logic [19:0] DELAY_RESET = 20'h00000;
  localparam logic [19:0] DELAY_MAX = 20'hF4240;
  localparam logic [19:0] THROUGHPUT_RESET = 20'h1A5E0;

  // ----------------------------------------------------------------
  // Offset bands, throughput in kB/s, offset in microseconds
  // ----------------------------------------------------------------
  localparam logic [19:0] BAND_WRAP = 20'h2EE70;
  localparam logic [19:0] BAND_1 = 20'h1A5E0;
  localparam logic [19:0] BAND_2 = 20'h222E0;
  localparam logic [19:0] BAND_3 = 20'h27114;
  localparam logic [19:0] BAND_4 = 20'h2BF20;
  localparam logic [7:0] OFS_BAND_1 = 8'h2A;
  localparam logic [7:0] OFS_BAND_2 = 8'h20;
  localparam logic [7:0] OFS_BAND_3 = 8'h1C;
  localparam logic [7:0] OFS_BAND_4 = 8'h19;
  localparam logic [7:0] OFS_BAND_5 = 8'h18;
  localparam logic [7:0] OFS_12BIT = 8'h1C;

  typedef struct packed {
    logic offset_variant;
    logic depth_12bit;
    logic width_mode;
    logic falling_edge;
    logic source_software;
    logic trig_enable;
  } twe_ctrl_type;

  localparam twe_ctrl_type CTRL_RESET = '0;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_DELAY,
    ST_EXPOSE,
    ST_OFFSET
  } twe_state_type;

endpackage : twe_pkg

// ==== twe_trigger_width_exposure_ctrl.sv ====
/*
  Frame start trigger and exposure timing controller with AHB-Lite slave.
  Assumes one 10 MHz clock, a synchronous active-high reset and an
  asynchronous trigger pin that is synchronised here.
*/
// How it works
// - Rising activation, width mode: expose from trigger rise to next fall.
// - Falling activation, width mode: period runs from fall to next rise.
// - Offset variant adds the exposure offset after the trigger period.
// - 8-bit pixels take offset from throughput bands, repeating above 192.112.
// - 12-bit pixels in the offset variant always use a 28 us offset.
// - Offset equals the minimum exposure time reported.
// - Timed modes subtract the offset so total equals programmed time.
// - Offset only extends the end; exposure start is never moved.
// - Overlap limit time steers the trigger wait output in width mode.
// - Programmed latency is inserted between hardware edge and action.
// - Latency 0 to 1000000 us; zero means no added delay.
// - Latency skipped for software triggers or triggering switched off.
// - Edge polarity setting picks rising or falling start edge.
// - Triggers ignored unless waiting; trigger during exposure flags overrun.
// - Timed mode takes length from exposure time starting at selected edge.
// - Input pin is trigger only when enabled and selected as source.
`timescale 1ns/1ps
module twe_trigger_width_exposure_ctrl
  import twe_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic trigger_line_i,
  output logic exposure_active_o,
  output logic trigger_wait_o,
  output logic overrun_o
);
  import twe_pkg::*;

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  twe_ctrl_type ctrl_q;
  twe_state_type state_q, state_d;
  logic [19:0] throughput_q, exp_time_q, overlap_q, delay_q;
  logic [19:0] us_cnt_q, target_q;
  logic [7:0] offset_q, offset_now;
  logic [3:0] tick_cnt_q;
  logic tick;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic sw_pulse_q;
  logic overrun_sticky_q;
  logic [2:0] line_sync_q;
  logic rise, fall, start_edge, end_edge;
  logic hw_trig, sw_trig, any_trig, exposing, ovr_clear;
  logic addr_phase;
  logic [19:0] band_tp;
  logic [19:0] wdata20;
  logic [19:0] timed_len;

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign addr_phase = hsel_i && hready_i && htrans_i[1];
  assign wdata20 = hwdata_i[19:0];

  // ----------------------------------------------------------------
  // Microsecond tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
    end
  end
  assign tick = (tick_cnt_q == TICK_LAST);

  // Split repeat keeps the unrolled sequence short
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (reset_i)
    tick |=> !tick [*8] ##1 !tick ##1 tick) else $error("tick not every 10 cycles");

  // ----------------------------------------------------------------
  // Trigger pin synchroniser and edges
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line_sync_q <= '0;
    end else begin
      line_sync_q <= {line_sync_q[1:0], trigger_line_i};
    end
  end
  assign rise = line_sync_q[1] && !line_sync_q[2];
  assign fall = !line_sync_q[1] && line_sync_q[2];
  assign start_edge = ctrl_q.falling_edge ? fall : rise;
  assign end_edge = ctrl_q.falling_edge ? rise : fall;
  assign hw_trig = ctrl_q.trig_enable && !ctrl_q.source_software && start_edge;
  assign sw_trig = ctrl_q.trig_enable && ctrl_q.source_software && sw_pulse_q;
  assign any_trig = hw_trig || sw_trig;
  assign exposing = (state_q == ST_EXPOSE) || (state_q == ST_OFFSET);

  // ----------------------------------------------------------------
  // Exposure offset selection
  // ----------------------------------------------------------------
  always_comb begin
    // Upper bands sit at twice the lower limits; halving rounds up so limits stay inclusive
    band_tp = (throughput_q > BAND_WRAP) ?
              (throughput_q >> 1) + {19'h00000, throughput_q[0]} : throughput_q;
    if (!ctrl_q.offset_variant) begin
      offset_now = 8'h00;
    end else if (ctrl_q.depth_12bit) begin
      offset_now = OFS_12BIT;
    end else if (band_tp <= BAND_1) begin
      offset_now = OFS_BAND_1;
    end else if (band_tp <= BAND_2) begin
      offset_now = OFS_BAND_2;
    end else if (band_tp <= BAND_3) begin
      offset_now = OFS_BAND_3;
    end else if (band_tp <= BAND_4) begin
      offset_now = OFS_BAND_4;
    end else begin
      offset_now = OFS_BAND_5;
    end
  end

  // Programmed time below the minimum is raised to the offset itself
  assign timed_len = (exp_time_q > {12'h000, offset_now}) ?
                     exp_time_q - {12'h000, offset_now} : 20'h00000;

  // ----------------------------------------------------------------
  // Exposure sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_WAIT: begin
        if (hw_trig && delay_q != 20'h00000) begin
          state_d = ST_DELAY;
        end else if (any_trig) begin
          state_d = ST_EXPOSE;
        end
      end
      ST_DELAY: begin
        if (!ctrl_q.trig_enable || ctrl_q.source_software) begin
          state_d = ST_WAIT;
        end else if (tick && us_cnt_q + 20'h00001 >= delay_q) begin
          state_d = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (ctrl_q.width_mode && end_edge) begin
          state_d = ST_OFFSET;
        end else if (!ctrl_q.width_mode && (target_q == 20'h00000 ||
                     (tick && us_cnt_q + 20'h00001 >= target_q))) begin
          state_d = ST_OFFSET;
        end
      end
      ST_OFFSET: begin
        if (offset_q == 8'h00 || (tick && us_cnt_q + 20'h00001 >= {12'h000, offset_q})) begin
          state_d = ST_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ST_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || state_d != state_q) begin
      us_cnt_q <= '0;
    end else if (tick) begin
      us_cnt_q <= us_cnt_q + 20'h00001;
    end
  end

  // Offset and length frozen at exposure start so a bus write mid-frame is harmless
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      offset_q <= '0;
      target_q <= '0;
    end else if (state_d == ST_EXPOSE && state_q != ST_EXPOSE) begin
      offset_q <= offset_now;
      target_q <= timed_len;
    end
  end

  a_wait_start: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_WAIT && hw_trig && delay_q == 20'h00000) |=> state_q == ST_EXPOSE)
    else $error("zero latency trigger did not start exposure");
  a_delay_used: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_WAIT && hw_trig && delay_q != 20'h00000) |=> state_q == ST_DELAY)
    else $error("latency not inserted");
  a_sw_nodelay: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_WAIT && sw_trig && !hw_trig) |=> state_q == ST_EXPOSE)
    else $error("software trigger delayed");
  a_width_end: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_EXPOSE && ctrl_q.width_mode && end_edge) |=> state_q == ST_OFFSET)
    else $error("opposite edge did not end trigger period");
  a_width_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_EXPOSE && ctrl_q.width_mode && !end_edge) |=> state_q == ST_EXPOSE)
    else $error("trigger period ended without edge");
  a_offset_len: assert property (@(posedge clk_i) disable iff (reset_i)
    ($rose(state_q == ST_OFFSET) && offset_q >= 8'h02) |->
    (state_q == ST_OFFSET) [*8] ##0 !(state_d == ST_WAIT))
    else $error("offset phase too short");
  a_twelve_bit: assert property (@(posedge clk_i) disable iff (reset_i)
    (ctrl_q.offset_variant && ctrl_q.depth_12bit) |-> offset_now == 8'h1C)
    else $error("12-bit offset not 28 us");
  a_band_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
    (ctrl_q.offset_variant && !ctrl_q.depth_12bit && throughput_q > 20'h2EE70 &&
     throughput_q <= 20'h34BC0) |-> offset_now == 8'h2A)
    else $error("band repetition wrong");
  a_offset_none: assert property (@(posedge clk_i) disable iff (reset_i)
    !ctrl_q.offset_variant |-> offset_now == 8'h00)
    else $error("offset added outside offset variant");
  a_delay_clamp: assert property (@(posedge clk_i) disable iff (reset_i)
    delay_q <= 20'hF4240)
    else $error("latency above one second");
  a_delay_abort: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_DELAY && ctrl_q.source_software) |=> state_q == ST_WAIT)
    else $error("latency kept for software source");

  // ----------------------------------------------------------------
  // Outputs and overrun
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overrun_o <= 1'b0;
    end else begin
      overrun_o <= exposing && any_trig;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overrun_sticky_q <= 1'b0;
    end else if (exposing && any_trig) begin
      overrun_sticky_q <= 1'b1;
    end else if (ovr_clear) begin
      overrun_sticky_q <= 1'b0;
    end
  end

  assign exposure_active_o = exposing;
  assign trigger_wait_o = ctrl_q.trig_enable && ((state_q == ST_WAIT) ||
    (state_q == ST_EXPOSE && ctrl_q.width_mode && us_cnt_q >= overlap_q));

  a_overrun_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (exposing && any_trig) |=> overrun_o && overrun_sticky_q)
    else $error("overrun not flagged");
  a_ignore_busy: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_DELAY && hw_trig && !tick) |=> state_q == ST_DELAY || state_q == ST_WAIT)
    else $error("busy trigger not ignored");
  a_wait_overlap: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_EXPOSE && ctrl_q.trig_enable && ctrl_q.width_mode && us_cnt_q < overlap_q)
    |-> !trigger_wait_o) else $error("wait raised before overlap limit");
  a_overlap_open: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_EXPOSE && ctrl_q.trig_enable && ctrl_q.width_mode && us_cnt_q >= overlap_q)
    |-> trigger_wait_o) else $error("wait not raised after overlap limit");
  a_disabled_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_WAIT && !ctrl_q.trig_enable) |=> state_q == ST_WAIT)
    else $error("trigger taken while triggering off");
  a_pin_unselected: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == ST_WAIT && ctrl_q.source_software && !sw_pulse_q) |=> state_q == ST_WAIT)
    else $error("pin taken while software source selected");

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_phase && hwrite_i;
      wr_addr_q <= haddr_i[7:0];
    end
  end

  assign ovr_clear = wr_pend_q && wr_addr_q == ADDR_STATUS && hwdata_i[STAT_OVERRUN_BIT];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q <= CTRL_RESET;
      throughput_q <= THROUGHPUT_RESET;
      exp_time_q <= EXP_TIME_RESET;
      overlap_q <= OVERLAP_RESET;
      delay_q <= DELAY_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        ADDR_CTRL: ctrl_q <= hwdata_i[5:0];
        ADDR_THROUGHPUT: throughput_q <= wdata20;
        ADDR_EXP_TIME: exp_time_q <= wdata20;
        ADDR_OVERLAP_MAX: overlap_q <= wdata20;
        ADDR_TRIG_DELAY: delay_q <= (wdata20 > DELAY_MAX) ? DELAY_MAX : wdata20;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sw_pulse_q <= 1'b0;
    end else begin
      sw_pulse_q <= wr_pend_q && wr_addr_q == ADDR_SW_TRIGGER && hwdata_i[0];
    end
  end

  // Read data is sampled in the address phase; zero wait states
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hrdata_o <= '0;
    end else if (addr_phase && !hwrite_i) begin
      case (haddr_i[7:0])
        ADDR_CTRL: hrdata_o <= {26'h0000000, ctrl_q};
        ADDR_THROUGHPUT: hrdata_o <= {12'h000, throughput_q};
        ADDR_EXP_TIME: hrdata_o <= {12'h000, exp_time_q};
        ADDR_OVERLAP_MAX: hrdata_o <= {12'h000, overlap_q};
        ADDR_TRIG_DELAY: hrdata_o <= {12'h000, delay_q};
        ADDR_STATUS: hrdata_o <= {16'h0000, offset_now, 4'h0, trigger_wait_o,
                                  overrun_sticky_q, exposing, state_q == ST_WAIT};
        ADDR_MIN_EXP: hrdata_o <= {24'h000000, offset_now};
        default: hrdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule // twe_trigger_width_exposure_ctrl

// ==== twe_trig_src.sv ====
/*
  Behavioural model of the external equipment that drives the trigger pin.
  Assumes the bench calls pulse() and that the pin is sampled asynchronously.
*/
`timescale 1ns/1ps
module twe_trig_src (
  input wire logic clk_i,
  output logic trigger_o
);
  logic lvl_q = 1'b0;
  assign trigger_o = lvl_q;
  // ------------------------------------------------------------
  // Pulse: idle level first, then active for n cycles
  // ------------------------------------------------------------
  // Off-edge changes, since the real pin has no relation to the clock
  task automatic pulse(input int n, input logic inv);
    lvl_q = inv;
    repeat (4) @(posedge clk_i);
    #7 lvl_q = ~inv;
    repeat (n) @(posedge clk_i);
    #7 lvl_q = inv;
  endtask
endmodule // twe_trig_src

// ==== tb.sv ====
/*
  Self-checking bench for the trigger width exposure controller.
  Assumes a zero-wait AHB-Lite slave and the trigger source model.
*/
`timescale 1ns/1ps
module tb;
  import twe_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] tput;
    logic [31:0] ofs;
  } twe_row_type;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rdv;
  logic hready, hresp, trig, expo, twait, ovr;
  int errors = 0;
  int samples_checked = 0;
  int st, len;
  bit seen;
  twe_row_type rows [12] = '{
    '{32'h20, 32'h1A5E0, 32'h2A}, '{32'h20, 32'h1A5E1, 32'h20}, '{32'h20, 32'h222E0, 32'h20},
    '{32'h20, 32'h27114, 32'h1C}, '{32'h20, 32'h27115, 32'h19}, '{32'h20, 32'h2BF20, 32'h19},
    '{32'h20, 32'h2EE70, 32'h18}, '{32'h20, 32'h2EE71, 32'h2A}, '{32'h20, 32'h3D090, 32'h20},
    '{32'h20, 32'h5DCE0, 32'h18}, '{32'h30, 32'h3D090, 32'h1C}, '{32'h30, 32'h1A5E0, 32'h1C}};

  always #50 clk_i = ~clk_i;

  twe_trigger_width_exposure_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .trigger_line_i(trig), .exposure_active_o(expo), .trigger_wait_o(twait), .overrun_o(ovr));
  twe_trig_src src (.clk_i(clk_i), .trigger_o(trig));

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, v, lo, hi);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Cycle counts are taken at falling edges, clear of register updates
  task automatic wait_hi;
    st = 0;
    while (expo !== 1'b1 && st < 20000) begin
      @(negedge clk_i);
      st++;
    end
    if (st >= 20000) errors++;
  endtask
  task automatic wait_lo;
    len = 0;
    while (expo === 1'b1 && len < 20000) begin
      @(negedge clk_i);
      len++;
    end
    if (len >= 20000) errors++;
  endtask
  task automatic expose(input int n, input logic inv);
    fork
      src.pulse(n, inv);
      begin
        wait_hi();
        wait_lo();
      end
    join
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h1A5E0);
    rc(8'h08, 32'hBB8);
    rc(8'h10, 32'h0);
    rc(8'h20, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, rows[i].ctrl);
      bus(1'b1, 8'h04, rows[i].tput);
      rc(8'h1C, rows[i].ofs);
      bus(1'b0, 8'h18, 32'h0);
      chk({24'h0, rdv[15:8]}, rows[i].ofs);
    end
    // Width mode, rising, no offset; wait level opens after 10 us
    bus(1'b1, 8'h0C, 32'h0A);
    bus(1'b1, 8'h00, 32'h09);
    expose(200, 1'b0);
    chk_rng(st, 6, 14);
    chk_rng(len, 198, 202);
    fork
      src.pulse(300, 1'b0);
      begin
        wait_hi();
        repeat (50) @(negedge clk_i);
        chk({31'h0, twait}, 32'h0);
        repeat (70) @(negedge clk_i);
        chk({31'h0, twait}, 32'h1);
      end
    join
    wait_lo();
    // 250 MB/s adds 32 us after the trigger period
    bus(1'b1, 8'h04, 32'h3D090);
    bus(1'b1, 8'h00, 32'h29);
    expose(680, 1'b0);
    chk_rng(st, 6, 14);
    chk_rng(len, 988, 1004);
    bus(1'b1, 8'h00, 32'h2D);
    expose(500, 1'b1);
    chk_rng(len, 808, 824);
    // Timed mode behind a 30 us latency
    bus(1'b1, 8'h00, 32'h21);
    bus(1'b1, 8'h10, 32'h1E);
    bus(1'b1, 8'h08, 32'h32);
    expose(20, 1'b0);
    chk_rng(st, 290, 324);
    chk_rng(len, 488, 504);
    // Second trigger inside a running exposure
    bus(1'b1, 8'h10, 32'h0);
    fork
      src.pulse(20, 1'b0);
      wait_hi();
    join
    seen = 0;
    fork
      src.pulse(20, 1'b0);
      repeat (40) begin
        @(negedge clk_i);
        if (ovr === 1'b1) seen = 1;
      end
    join
    chk({31'h0, seen}, 32'h1);
    wait_lo();
    chk_rng(len, 430, 480);
    bus(1'b0, 8'h18, 32'h0);
    chk({31'h0, rdv[2]}, 32'h1);
    bus(1'b1, 8'h18, 32'h4);
    bus(1'b0, 8'h18, 32'h0);
    chk({31'h0, rdv[2]}, 32'h0);
    // Latency clamps; software trigger ignores it
    bus(1'b1, 8'h10, 32'hFFFFFF);
    rc(8'h10, 32'hF4240);
    bus(1'b1, 8'h00, 32'h23);
    bus(1'b1, 8'h14, 32'h1);
    wait_hi();
    chk_rng(st, 0, 10);
    wait_lo();
    // Pin ignored while triggering is off
    bus(1'b1, 8'h00, 32'h08);
    seen = 0;
    fork
      src.pulse(50, 1'b0);
      repeat (80) begin
        @(negedge clk_i);
        if (expo === 1'b1) seen = 1;
      end
    join
    chk({31'h0, seen}, 32'h0);
    // Reset in mid-run brings written registers back
    bus(1'b1, 8'h0C, 32'h55);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rc(8'h00, 32'h0);
    rc(8'h0C, 32'h0);
    rc(8'h04, 32'h1A5E0);
    tally_and_finish();
  end
endmodule // tb
